// ---- design/fbd_map.svh ----
`ifndef FBD_MAP_SVH
`define FBD_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets (12-bit address space)
// ---------------------------------------------------------------
`define FBD_OFS_TEMP_VAL 12'h000
`define FBD_OFS_BOOST_LIM 12'h010
`define FBD_OFS_BOOST_HYST 12'h020
`define FBD_OFS_TACH_CTRL 12'h024
`define FBD_OFS_TACH_MASK 12'h028
`define FBD_OFS_TACH_LIM 12'h030
`define FBD_OFS_TEMP_LIM 12'h040
`define FBD_OFS_ST_BMC 12'h050
`define FBD_OFS_ST_HOST 12'h054
`define FBD_OFS_VOLT_VAL 12'h080
`define FBD_OFS_VOLT_LO 12'h0c0
`define FBD_OFS_VOLT_HI 12'h100

// ---------------------------------------------------------------
// Reset values and special codes
// ---------------------------------------------------------------
`define FBD_RST_BOOST_LIM_12 8'h3c
`define FBD_RST_BOOST_LIM_34 8'h23
`define FBD_RST_BOOST_HYST 16'h4444
`define FBD_RST_TEMP_LIM 8'h7f
`define FBD_RST_TACH_LIM 16'hffff
`define FBD_RST_VOLT_LO 8'h00
`define FBD_RST_VOLT_HI 8'hff
`define FBD_TEMP_FAULT 8'h80
`define FBD_DUTY_FULL 8'hff

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FBD_TC_EN 3:0
`define FBD_TC_BIND_A 7:4
`define FBD_TC_BIND_B 11:8
`define FBD_TC_TMO 23:16
`define FBD_ST_DIODE 3:0
`define FBD_ST_TEMP 7:4
`define FBD_ST_TACH 11:8
`define FBD_ST_VOLT 27:12
`define FBD_ST_W 28

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FBD_CLK_MHZ 40
`define FBD_TICK_US 1000
`define FBD_TICK_CYCLES (`FBD_TICK_US * `FBD_CLK_MHZ)

`endif

// ---- design/fbd_pkg.sv ----
package fbd_pkg;
   typedef logic signed [7:0] fbd_temp_t;
   typedef logic [7:0] fbd_duty_t;
   typedef logic [15:0] fbd_tach_t;
   typedef logic [7:0] fbd_volt_t;
endpackage

// ---- design/fbd_zone_boost.sv ----
`timescale 1ns/1ps
`include "fbd_map.svh"

// Boost detector for one temperature zone with hysteresis
module fbd_zone_boost (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Zone reading and settings
   input wire fbd_pkg::fbd_temp_t temp,
   input wire fbd_pkg::fbd_temp_t limit,
   input wire logic [3:0] hyst,
   // Boost level
   output logic boost
);
   logic boost_r;
   logic signed [8:0] release_lvl;
   logic masked;
   logic above;
   logic below;

   // Release threshold computed one bit wider so it never wraps
   assign release_lvl = 9'(limit) - $signed({5'h00, hyst});
   assign masked = (limit == `FBD_TEMP_FAULT);
   assign above = !masked && (temp > limit);
   assign below = masked || (9'(temp) <= release_lvl);
   assign boost = boost_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boost_r <= 1'b0;
      end else if (above) begin
         boost_r <= 1'b1;
      end else if (below) begin
         boost_r <= 1'b0;
      end
   end
endmodule // fbd_zone_boost

// ---- design/fbd_tach_hold.sv ----
`timescale 1ns/1ps
`include "fbd_map.svh"

// Hold-off timer keeping one fan output at full after a tach error
module fbd_tach_hold (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Error level, tick and timeout in ticks
   input wire logic err,
   input wire logic tick,
   input wire logic [7:0] timeout,
   // Boost level
   output logic boost
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   assign cnt_nxt = err ? timeout :
                    (tick && cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
   assign boost = err || (cnt_r != 8'h00);

   // Counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // fbd_tach_hold

// ---- design/fbd_top.sv ----
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "fbd_map.svh"

// What this block does
// - Check diode open/short before committing reading
// - Diode fault sets status fault bit
// - Faulted zone reading becomes 80h
// - Temperature boost drives both outputs full
// - Boost when zone exceeds its limit
// - Boost holds until limit minus hysteresis
// - Boost limits reset 60C and 35C
// - Tach boost only when enabled
// - Tach error when count exceeds limit
// - Unmasked tach error drives bound outputs full
// - Hold outputs full for timeout after error
// - Recurring error restarts timeout after it ends
// - Supply voltages stored as 8-bit readings
// - Nominal internal rail reads C0h
// - Twelve-volt input full scale reads FFh
// - Limit violations set both mirrored status sets
// - Temperature limit 80h masks comparison
module fbd_top #(
   parameter int TICK_CYCLES = `FBD_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Temperature conversion results
   input wire logic temp_valid,
   input wire logic [1:0] temp_zone,
   input wire fbd_pkg::fbd_temp_t temp_data,
   input wire logic diode_open,
   input wire logic diode_short,
   // Tachometer results
   input wire logic tach_valid,
   input wire logic [1:0] tach_chan,
   input wire fbd_pkg::fbd_tach_t tach_count,
   // Voltage conversion results
   input wire logic volt_valid,
   input wire logic [3:0] volt_chan,
   input wire fbd_pkg::fbd_volt_t volt_code,
   // Duty from normal fan control
   input wire fbd_pkg::fbd_duty_t duty_a_in,
   input wire fbd_pkg::fbd_duty_t duty_b_in,
   // Fan drive and boost state
   output fbd_pkg::fbd_duty_t fan_drive_out_a,
   output fbd_pkg::fbd_duty_t fan_drive_out_b,
   output logic temp_boost,
   output logic tach_boost_a,
   output logic tach_boost_b
);
   // ---------------------------------------------------------------
   // Address helpers
   // ---------------------------------------------------------------
   // True when addr falls on a word inside an n-entry array at base
   function automatic logic fbd_hit(input logic [11:0] addr,
                                    input logic [11:0] base,
                                    input logic [11:0] n);
      fbd_hit = (addr[1:0] == 2'b00) && (addr >= base) &&
                (addr < base + (n << 2));
   endfunction

   // Word index of addr inside an array at base
   function automatic logic [3:0] fbd_idx(input logic [11:0] addr,
                                          input logic [11:0] base);
      logic [11:0] d;
      d = addr - base;
      fbd_idx = d[5:2];
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   fbd_pkg::fbd_temp_t temp_val_r [4];
   fbd_pkg::fbd_temp_t boost_lim_r [4];
   fbd_pkg::fbd_temp_t temp_lim_r [4];
   fbd_pkg::fbd_tach_t tach_lim_r [4];
   fbd_pkg::fbd_volt_t volt_val_r [16];
   fbd_pkg::fbd_volt_t volt_lo_r [16];
   fbd_pkg::fbd_volt_t volt_hi_r [16];
   logic [15:0] boost_hyst_r;
   logic [31:0] tach_ctrl_r;
   logic [3:0] tach_mask_r;
   logic [3:0] tach_err_r;
   logic [`FBD_ST_W-1:0] st_bmc_r;
   logic [`FBD_ST_W-1:0] st_host_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   fbd_pkg::fbd_duty_t drive_a_r;
   fbd_pkg::fbd_duty_t drive_b_r;
   logic [15:0] tick_cnt_r;
   logic tick_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic wr_en;
   logic rd_setup;
   logic hit_tval, hit_blim, hit_tlim, hit_tachl, hit_vval, hit_vlo, hit_vhi;
   logic hit_hyst, hit_tctl, hit_tmsk, hit_sbmc, hit_shost;
   logic hit_any;
   logic [3:0] widx;

   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign hit_tval = fbd_hit(paddr, `FBD_OFS_TEMP_VAL, 12'h004);
   assign hit_blim = fbd_hit(paddr, `FBD_OFS_BOOST_LIM, 12'h004);
   assign hit_tlim = fbd_hit(paddr, `FBD_OFS_TEMP_LIM, 12'h004);
   assign hit_tachl = fbd_hit(paddr, `FBD_OFS_TACH_LIM, 12'h004);
   assign hit_vval = fbd_hit(paddr, `FBD_OFS_VOLT_VAL, 12'h010);
   assign hit_vlo = fbd_hit(paddr, `FBD_OFS_VOLT_LO, 12'h010);
   assign hit_vhi = fbd_hit(paddr, `FBD_OFS_VOLT_HI, 12'h010);
   assign hit_hyst = (paddr == `FBD_OFS_BOOST_HYST);
   assign hit_tctl = (paddr == `FBD_OFS_TACH_CTRL);
   assign hit_tmsk = (paddr == `FBD_OFS_TACH_MASK);
   assign hit_sbmc = (paddr == `FBD_OFS_ST_BMC);
   assign hit_shost = (paddr == `FBD_OFS_ST_HOST);
   assign hit_any = hit_tval | hit_blim | hit_tlim | hit_tachl | hit_vval |
                    hit_vlo | hit_vhi | hit_hyst | hit_tctl | hit_tmsk |
                    hit_sbmc | hit_shost;
   assign widx = hit_vval ? fbd_idx(paddr, `FBD_OFS_VOLT_VAL) :
                 hit_vlo ? fbd_idx(paddr, `FBD_OFS_VOLT_LO) :
                 hit_vhi ? fbd_idx(paddr, `FBD_OFS_VOLT_HI) :
                 hit_blim ? fbd_idx(paddr, `FBD_OFS_BOOST_LIM) :
                 hit_tlim ? fbd_idx(paddr, `FBD_OFS_TEMP_LIM) :
                 hit_tachl ? fbd_idx(paddr, `FBD_OFS_TACH_LIM) :
                 fbd_idx(paddr, `FBD_OFS_TEMP_VAL);

   // Read mux; read-only value arrays ignore writes
   logic [31:0] rd_mux;
   assign rd_mux = hit_tval ? {24'h000000, temp_val_r[widx[1:0]]} :
                   hit_blim ? {24'h000000, boost_lim_r[widx[1:0]]} :
                   hit_tlim ? {24'h000000, temp_lim_r[widx[1:0]]} :
                   hit_tachl ? {16'h0000, tach_lim_r[widx[1:0]]} :
                   hit_vval ? {24'h000000, volt_val_r[widx]} :
                   hit_vlo ? {24'h000000, volt_lo_r[widx]} :
                   hit_vhi ? {24'h000000, volt_hi_r[widx]} :
                   hit_hyst ? {16'h0000, boost_hyst_r} :
                   hit_tctl ? {8'h00, tach_ctrl_r[23:0]} :
                   hit_tmsk ? {28'h0000000, tach_mask_r} :
                   hit_sbmc ? {4'h0, st_bmc_r} :
                   hit_shost ? {4'h0, st_host_r} : 32'h00000000;

   // Zero-wait slave: data is captured in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // Read data and error flag for the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (rd_setup) begin
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
         pslverr_r <= !hit_any;
      end
   end

   // ---------------------------------------------------------------
   // Conversion commit and limit checks
   // ---------------------------------------------------------------
   logic diode_fault;
   fbd_pkg::fbd_temp_t temp_commit;
   logic temp_over;
   logic [3:0] zone_hot;
   logic [3:0] tach_hot;
   logic [15:0] volt_hot;
   logic [`FBD_ST_W-1:0] st_set;

   assign diode_fault = diode_open || diode_short;
   assign temp_commit = diode_fault ? `FBD_TEMP_FAULT : temp_data;
   assign temp_over = !diode_fault &&
                      (temp_lim_r[temp_zone] != `FBD_TEMP_FAULT) &&
                      (temp_data > temp_lim_r[temp_zone]);
   assign zone_hot = 4'h1 << temp_zone;
   assign tach_hot = (tach_valid && tach_count > tach_lim_r[tach_chan]) ?
                     (4'h1 << tach_chan) : 4'h0;
   assign volt_hot = (volt_valid && (volt_code < volt_lo_r[volt_chan] ||
                      volt_code > volt_hi_r[volt_chan])) ?
                     (16'h0001 << volt_chan) : 16'h0000;

   assign st_set[`FBD_ST_DIODE] = (temp_valid && diode_fault) ? zone_hot : 4'h0;
   assign st_set[`FBD_ST_TEMP] = (temp_valid && temp_over) ? zone_hot : 4'h0;
   assign st_set[`FBD_ST_TACH] = tach_hot;
   assign st_set[`FBD_ST_VOLT] = volt_hot;

   // both mirrors set, a new event wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_bmc_r <= '0;
         st_host_r <= '0;
      end else begin
         st_bmc_r <= (st_bmc_r & ~((wr_en && hit_sbmc) ?
                     pwdata[`FBD_ST_W-1:0] : '0)) | st_set;
         st_host_r <= (st_host_r & ~((wr_en && hit_shost) ?
                      pwdata[`FBD_ST_W-1:0] : '0)) | st_set;
      end
   end

   // Value arrays; each rail kept as an 8-bit code
   // scaling is analog, code stored as converted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            temp_val_r[i] <= 8'h00;
         end
         for (int i = 0; i < 16; i++) begin
            volt_val_r[i] <= 8'h00;
         end
         tach_err_r <= 4'h0;
      end else begin
         if (temp_valid) begin
            temp_val_r[temp_zone] <= temp_commit;
         end
         if (volt_valid) begin
            volt_val_r[volt_chan] <= volt_code;
         end
         if (tach_valid) begin
            tach_err_r[tach_chan] <= (tach_hot != 4'h0);
         end
      end
   end

   // ---------------------------------------------------------------
   // Writable settings
   // ---------------------------------------------------------------
   // boost limit reset values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boost_lim_r[0] <= `FBD_RST_BOOST_LIM_12;
         boost_lim_r[1] <= `FBD_RST_BOOST_LIM_12;
         boost_lim_r[2] <= `FBD_RST_BOOST_LIM_34;
         boost_lim_r[3] <= `FBD_RST_BOOST_LIM_34;
         for (int i = 0; i < 4; i++) begin
            temp_lim_r[i] <= `FBD_RST_TEMP_LIM;
            tach_lim_r[i] <= `FBD_RST_TACH_LIM;
         end
         for (int i = 0; i < 16; i++) begin
            volt_lo_r[i] <= `FBD_RST_VOLT_LO;
            volt_hi_r[i] <= `FBD_RST_VOLT_HI;
         end
         boost_hyst_r <= `FBD_RST_BOOST_HYST;
         tach_ctrl_r <= 32'h00000000;
         tach_mask_r <= 4'h0;
      end else if (wr_en) begin
         if (hit_blim) boost_lim_r[widx[1:0]] <= pwdata[7:0];
         if (hit_tlim) temp_lim_r[widx[1:0]] <= pwdata[7:0];
         if (hit_tachl) tach_lim_r[widx[1:0]] <= pwdata[15:0];
         if (hit_vlo) volt_lo_r[widx] <= pwdata[7:0];
         if (hit_vhi) volt_hi_r[widx] <= pwdata[7:0];
         if (hit_hyst) boost_hyst_r <= pwdata[15:0];
         if (hit_tctl) tach_ctrl_r <= {8'h00, pwdata[23:0]};
         if (hit_tmsk) tach_mask_r <= pwdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Boost logic
   // ---------------------------------------------------------------
   logic [3:0] zone_boost;

   // One hysteresis detector per zone
   generate
      for (genvar z = 0; z < 4; z++) begin : g_zone
         fbd_zone_boost u_zone (
            .clk(clk),
            .rst_n(rst_n),
            .temp(temp_val_r[z]),
            .limit(boost_lim_r[z]),
            .hyst(boost_hyst_r[4*z +: 4]),
            .boost(zone_boost[z])
         );
      end
   endgenerate

   assign temp_boost = |zone_boost;

   // Millisecond tick for the hold-off timers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r <= 1'b0;
      end
   end

   logic [3:0] tach_live;
   logic err_a;
   logic err_b;

   assign tach_live = tach_err_r & tach_ctrl_r[`FBD_TC_EN] & ~tach_mask_r;
   assign err_a = |(tach_live & tach_ctrl_r[`FBD_TC_BIND_A]);
   assign err_b = |(tach_live & tach_ctrl_r[`FBD_TC_BIND_B]);

   fbd_tach_hold u_hold_a (
      .clk(clk),
      .rst_n(rst_n),
      .err(err_a),
      .tick(tick_r),
      .timeout(tach_ctrl_r[`FBD_TC_TMO]),
      .boost(tach_boost_a)
   );

   fbd_tach_hold u_hold_b (
      .clk(clk),
      .rst_n(rst_n),
      .err(err_b),
      .tick(tick_r),
      .timeout(tach_ctrl_r[`FBD_TC_TMO]),
      .boost(tach_boost_b)
   );

   // tach boost forces its output full
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_a_r <= 8'h00;
         drive_b_r <= 8'h00;
      end else begin
         drive_a_r <= (temp_boost || tach_boost_a) ? `FBD_DUTY_FULL : duty_a_in;
         drive_b_r <= (temp_boost || tach_boost_b) ? `FBD_DUTY_FULL : duty_b_in;
      end
   end

   assign fan_drive_out_a = drive_a_r;
   assign fan_drive_out_b = drive_b_r;
endmodule // fbd_top

// ---- dv/fbd_fan_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Fan and tachometer stand-in
// ----------------------------------------
module fbd_fan_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Drive seen by the fans, stall request per tach channel
   input wire fbd_pkg::fbd_duty_t fan_drive_out_a,
   input wire fbd_pkg::fbd_duty_t fan_drive_out_b,
   input wire logic [3:0] stall,
   // Tachometer results
   output logic tach_valid,
   output logic [1:0] tach_chan,
   output fbd_pkg::fbd_tach_t tach_count
);
   logic [4:0] cnt_r;
   logic fire;
   fbd_pkg::fbd_duty_t duty;

   // Channels 0-1 sit on drive a, 2-3 on drive b; one result every 8 cycles
   assign duty = cnt_r[4] ? fan_drive_out_b : fan_drive_out_a;
   assign fire = (cnt_r[2:0] == 3'h7);

   // Faster fan gives a shorter period count; a stalled fan a huge one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
         tach_valid <= 1'b0;
         tach_chan <= 2'h0;
         tach_count <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         tach_valid <= fire;
         tach_chan <= cnt_r[4:3];
         if (fire) begin
            tach_count <= stall[cnt_r[4:3]] ? 16'hf000 : {4'h0, ~duty, 4'h0};
         end else begin
            tach_count <= ~tach_count; // Count flips to its inverse each cycle between results
         end
      end
   end
endmodule // fbd_fan_model

// ---- dv/fbd_top_asserts.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module fbd_top_chk #(
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register reads
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   // Results in
   input wire logic temp_valid,
   input wire logic [1:0] temp_zone,
   input wire fbd_pkg::fbd_temp_t temp_data,
   input wire logic diode_open,
   input wire logic diode_short,
   input wire logic tach_valid,
   // Duty and boost
   input wire fbd_pkg::fbd_duty_t duty_a_in,
   input wire fbd_pkg::fbd_duty_t duty_b_in,
   input wire fbd_pkg::fbd_duty_t fan_drive_out_a,
   input wire fbd_pkg::fbd_duty_t fan_drive_out_b,
   input wire logic temp_boost,
   input wire logic tach_boost_a
);
   logic [7:0] tv_r [4];

   // Shadow of committed zone values; a fault commits the fault code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tv_r <= '{default: 8'h00};
      end else if (temp_valid) begin
         tv_r[temp_zone] <= (diode_open || diode_short) ? 8'h80 : temp_data;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   temp_full_a: assert property (
      temp_boost |=> fan_drive_out_a == 8'hff && fan_drive_out_b == 8'hff)
      else $error("drive not full on temp boost");
   tach_full_a: assert property (
      tach_boost_a |=> fan_drive_out_a == 8'hff) else $error("drive a not full on tach boost");
   follow_a_a: assert property (
      !temp_boost && !tach_boost_a |=> fan_drive_out_a == $past(duty_a_in))
      else $error("drive a not following duty");
   follow_b_a: assert property (
      !temp_boost |=> fan_drive_out_b == $past(duty_b_in) || fan_drive_out_b == 8'hff)
      else $error("drive b neither duty nor full");
   boost_cause_a: assert property (
      $rose(temp_boost) |-> $past(temp_valid, 2)) else $error("boost rose without reading");
   boost_off_a: assert property (
      $fell(temp_boost) |-> $past(temp_valid, 2)) else $error("boost fell without reading");
   tach_cause_a: assert property (
      $rose(tach_boost_a) |-> $past(tach_valid)) else $error("tach boost without result");
   temp_read_a: assert property (
      psel && penable && !pwrite && paddr[11:4] == 8'h00
      |-> prdata == {24'h0, tv_r[paddr[3:2]]}) else $error("zone value read wrong");

   cover property ($rose(temp_boost));
   cover property ($rose(tach_boost_a));
   cover property ($fell(tach_boost_a));
endmodule // fbd_top_chk

bind fbd_top fbd_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .temp_valid(temp_valid), .temp_zone(temp_zone),
   .temp_data(temp_data), .diode_open(diode_open), .diode_short(diode_short),
   .tach_valid(tach_valid), .duty_a_in(duty_a_in), .duty_b_in(duty_b_in),
   .fan_drive_out_a(fan_drive_out_a), .fan_drive_out_b(fan_drive_out_b),
   .temp_boost(temp_boost), .tach_boost_a(tach_boost_a)
);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Bench for the fan boost and diode fault block
// ----------------------------------------
module testbench;
   localparam int TICK = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic temp_valid = 1'b0;
   logic [1:0] temp_zone = 2'h0;
   fbd_pkg::fbd_temp_t temp_data = 8'h00;
   logic diode_open = 1'b0;
   logic diode_short = 1'b0;
   logic tach_valid;
   logic [1:0] tach_chan;
   fbd_pkg::fbd_tach_t tach_count;
   logic volt_valid = 1'b0;
   logic [3:0] volt_chan = 4'h0;
   fbd_pkg::fbd_volt_t volt_code = 8'h00;
   fbd_pkg::fbd_duty_t duty_a_in = 8'h40;
   fbd_pkg::fbd_duty_t duty_b_in = 8'h90;
   fbd_pkg::fbd_duty_t fan_drive_out_a;
   fbd_pkg::fbd_duty_t fan_drive_out_b;
   logic temp_boost;
   logic tach_boost_a;
   logic tach_boost_b;
   logic [3:0] stall = 4'h0;
   logic [31:0] rd;
   logic er;
   int n_fail = 0;
   int check_count = 0;
   int n;
   // Zone, open, short, reading, stored value, boost expected
   logic [20:0] rows [10] = '{
      {2'd0, 2'b00, 8'h19, 8'h19, 1'b0}, {2'd1, 2'b10, 8'h7f, 8'h80, 1'b0},
      {2'd2, 2'b01, 8'h10, 8'h80, 1'b0}, {2'd3, 2'b00, 8'hc9, 8'hc9, 1'b0},
      {2'd0, 2'b00, 8'h3c, 8'h3c, 1'b0}, {2'd0, 2'b00, 8'h3d, 8'h3d, 1'b1},
      {2'd0, 2'b00, 8'h39, 8'h39, 1'b1}, {2'd0, 2'b00, 8'h38, 8'h38, 1'b0},
      {2'd2, 2'b00, 8'h24, 8'h24, 1'b1}, {2'd2, 2'b00, 8'h1f, 8'h1f, 1'b0}};

   fbd_top #(.TICK_CYCLES(TICK)) dut (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .temp_valid(temp_valid), .temp_zone(temp_zone), .temp_data(temp_data),
      .diode_open(diode_open), .diode_short(diode_short), .tach_valid(tach_valid),
      .tach_chan(tach_chan), .tach_count(tach_count), .volt_valid(volt_valid),
      .volt_chan(volt_chan), .volt_code(volt_code), .duty_a_in(duty_a_in),
      .duty_b_in(duty_b_in), .fan_drive_out_a(fan_drive_out_a),
      .fan_drive_out_b(fan_drive_out_b), .temp_boost(temp_boost),
      .tach_boost_a(tach_boost_a), .tach_boost_b(tach_boost_b));

   fbd_fan_model u_fan (.clk(clk), .rst_n(rst_n), .fan_drive_out_a(fan_drive_out_a),
      .fan_drive_out_b(fan_drive_out_b), .stall(stall), .tach_valid(tach_valid),
      .tach_chan(tach_chan), .tach_count(tach_count));

   // Clock
   always #12.5 clk = ~clk;

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One bus transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask

   task automatic tcommit(input logic [1:0] z, input logic [1:0] f, input logic [7:0] d);
      temp_valid <= 1'b1;
      temp_zone <= z;
      diode_open <= f[1];
      diode_short <= f[0];
      temp_data <= d;
      @(posedge clk);
      temp_valid <= 1'b0;
      @(posedge clk);
   endtask

   // Wait for a channel 0 result that is (or is not) over the tach limit
   task automatic waitt(input logic over);
      do begin
         @(posedge clk);
      end while (!(tach_valid === 1'b1 && tach_chan === 2'd0
         && (tach_count > 16'h1000) == over));
   endtask

   task automatic end_of_test();
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog at 20000 cycles, well beyond the under one thousand cycles the tests need
   initial begin
      #(25 * 20000);
      n_fail++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         tcommit(rows[i][20:19], rows[i][18:17], rows[i][16:9]);
         repeat (3) @(posedge clk);
         chk(temp_boost, rows[i][0]);
         chk(fan_drive_out_a, rows[i][0] ? 8'hff : duty_a_in);
         chk(fan_drive_out_b, rows[i][0] ? 8'hff : duty_b_in);
         rdchk({8'h0, rows[i][20:19], 2'b00}, {24'h0, rows[i][8:1]});
      end
      $display("test rows done");
      rdchk(12'h050, 32'h6);
      rdchk(12'h054, 32'h6);
      apb(1'b1, 12'h054, 32'hf);
      rdchk(12'h054, 32'h0);
      rdchk(12'h050, 32'h6);
      apb(1'b1, 12'h050, 32'hff);
      apb(1'b1, 12'h040, 32'h10);
      tcommit(2'd0, 2'b00, 8'h14);
      rdchk(12'h050, 32'h10);
      apb(1'b1, 12'h040, 32'h80);
      apb(1'b1, 12'h050, 32'hff);
      tcommit(2'd0, 2'b00, 8'h14);
      rdchk(12'h050, 32'h0);
      $display("test status done");
      for (int i = 0; i < 16; i++) begin
         volt_valid <= 1'b1;
         volt_chan <= i[3:0];
         volt_code <= (i == 0) ? 8'hff : ((i == 14) ? 8'h40 : 8'hc0);
         @(posedge clk);
         volt_valid <= 1'b0;
         @(posedge clk);
         rdchk(12'h080 + 12'(i * 4), (i == 0) ? 32'hff : ((i == 14) ? 32'h40 : 32'hc0));
      end
      apb(1'b0, 12'hffc, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      chk(pready, 1'b1);
      $display("test volt done");
      apb(1'b1, 12'h030, 32'h1000);
      apb(1'b1, 12'h024, 32'h0014_0011);
      stall <= 4'h1;
      waitt(1'b1);
      @(posedge clk);
      chk(tach_boost_a, 1'b1);
      chk(tach_boost_b, 1'b0);
      stall <= 4'h0;
      waitt(1'b0);
      repeat (40) @(posedge clk);
      chk(tach_boost_a, 1'b1);
      stall <= 4'h1;
      waitt(1'b1);
      stall <= 4'h0;
      waitt(1'b0);
      n = 0;
      while (tach_boost_a === 1'b1 && n < 200) begin
         n++;
         @(posedge clk);
      end
      chk(n >= 19 * TICK && n <= 20 * TICK + 4, 1'b1);
      apb(1'b1, 12'h028, 32'h1);
      stall <= 4'h1;
      waitt(1'b1);
      repeat (2) @(posedge clk);
      chk(tach_boost_a, 1'b0);
      chk(fan_drive_out_a, duty_a_in);
      stall <= 4'h0;
      $display("test tach done");
      // limits back to defaults after a mid-run reset
      apb(1'b1, 12'h010, 32'h70);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(fan_drive_out_a, 8'h00);
      chk(temp_boost, 1'b0);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rdchk(12'h010 + 12'(i * 4), (i < 2) ? 32'h3c : 32'h23);
      end
      rdchk(12'h020, 32'h4444);
      $display("test reset done");
      end_of_test();
   end
endmodule // testbench
